// >>> pkg/ldr_pkg.sv
// Purpose: constants for the loop output converter register bank
// Assumes: 125 MHz system clock, 24-bit serial frames
// Notes: register offsets are command addresses, bit 7 marks a read
package ldr_pkg;
	// frame layout
	localparam int FRAME_BITS = 24; // bits per frame
	localparam int CMD_MSB = 23; // command byte top bit
	localparam int CMD_LSB = 16; // command byte low bit
	localparam int READ_BIT = 7; // command bit that selects a read
	// register addresses
	localparam logic [6:0] ADDR_COMMIT = 7'h01; // write only
	localparam logic [6:0] ADDR_NOP = 7'h02; // no operation
	localparam logic [6:0] ADDR_WR_POLICY = 7'h03; // write policy
	localparam logic [6:0] ADDR_CODE = 7'h04; // output code
	localparam logic [6:0] ADDR_FAULT_SETUP = 7'h05; // fault setup
	localparam logic [6:0] ADDR_LAST_WRITABLE = 7'h08; // top of writable map
	// command values and reset values
	localparam logic [15:0] COMMIT_VALUE = 16'h00FF; // commit key
	localparam logic [15:0] WR_POLICY_RST = 16'h0000; // guard off
	localparam logic [15:0] FAULT_SETUP_RST = 16'h0102; // retry 1, timeout 1
	localparam logic [15:0] CODE_RST_LOW = 16'h2400; // polarity pin low
	localparam logic [15:0] CODE_RST_HIGH = 16'hE800; // polarity pin high
	localparam logic [15:0] WR_POLICY_MASK = 16'h0001; // defined bits
	localparam logic [15:0] FAULT_SETUP_MASK = 16'h07FF; // defined bits
	// fault setup fields
	localparam int GUARD_BIT = 0; // write policy guard bit
	localparam int RETRY_MSB = 10; // loop retry field top
	localparam int RETRY_LSB = 8; // loop retry field low
	localparam int RETRY_DIS_BIT = 7; // retry disable
	localparam int LOOP_MASK_BIT = 6; // loop fault current mask
	localparam int LOOP_PIN_DIS_BIT = 5; // loop fault pin disable
	localparam int TOUT_CUR_MASK_BIT = 4; // timeout current mask
	localparam int TOUT_MSB = 3; // timeout field top
	localparam int TOUT_LSB = 1; // timeout field low
	localparam int TOUT_REPORT_MASK_BIT = 0; // timeout report mask
	// timing
	localparam int SYS_CLK_KHZ = 125000; // system clock rate
	localparam int TICK_MS = 50; // timer step in ms
	localparam int TICK_CYCLES = TICK_MS * SYS_CLK_KHZ; // cycles per step
	localparam int SYNC_STAGES = 3; // pin synchroniser depth
endpackage

// >>> logic/ldr_bank.sv
// Purpose: register bank, serial frame capture and fault timers
// Assumes: serial clock stops while select_n is high
// Notes on behaviour
// - undefined bits ignored on write, read zero
// - commit key 0x00FF at 0x01 loads pending
// - no-operation write changes nothing, counts activity
// - guard off: write applies at frame end
// - guard on: write waits for commit
// - output code is 16-bit unsigned at 0x04
// - reset code from polarity pin level
// - fault setup resets to 0x0102
// - retry spacing is (field+1) times 50 ms
// - retry idle when masked or clear
// - retry periodically restores code during fault
// - retry disabled: restore after status read
// - unmasked loop fault selects low alarm
// - loop fault pulls fault pin unless disabled
// - timeout forces polarity-chosen alarm unless masked
// - valid write restarts inactivity timer
// - timeout limit is (field+1) times 50 ms
// - timeout drives fault pin unless masked
// - frames a whole multiple of 24 bits, msb first, else framing fault
// - read command returns data next frame
// - loop fault wins over timeout level
// - valid write clears timeout fault
module ldr_bank import ldr_pkg::*; #(
	parameter int TICKS = TICK_CYCLES // cycles per 50 ms step
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic link_clk,
	input wire logic select_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	input wire logic alarm_polarity_pin,
	input wire logic loop_fault,
	input wire logic status_read,
	input wire logic [7:0] alarm_low,
	input wire logic [7:0] alarm_high,
	output logic [15:0] output_code,
	output logic fault_pin_n,
	output logic fault_pin_oe,
	output logic timeout_fault,
	output logic framing_fault_flag
);
	// elaboration check: the divider needs at least two counts
	if (TICKS < 2) begin : g_bad_ticks
		$error("tick count too small");
	end

	// ---- link domain ----
	logic seen_q; // frame has had a rising edge
	logic oseen_q; // frame has had a falling edge
	logic [4:0] cnt_q; // bit count modulo frame length
	logic got_q; // at least one whole frame seen
	logic tog_q; // flips at each frame start
	logic [23:0] sr_q; // shift register
	logic miso_q; // output bit
	logic [23:0] rd_q; // word shown in the next frame

	// frame activity flag, cleared while deselected
	always_ff @(posedge link_clk or posedge select_n) begin
		if (select_n) begin
			seen_q <= 1'b0;
		end else begin
			seen_q <= 1'b1;
		end
	end

	// falling-edge flag gates the first output change
	always_ff @(negedge link_clk or posedge select_n) begin
		if (select_n) begin
			oseen_q <= 1'b0;
		end else begin
			oseen_q <= 1'b1;
		end
	end

	// frame start toggle, reset from system reset
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			tog_q <= 1'b0;
		end else if (!seen_q) begin
			tog_q <= ~tog_q;
		end
	end

	// shift in msb first, count bits
	always_ff @(posedge link_clk) begin
		if (!seen_q) begin
			// first edge loads the reply word
			sr_q <= {rd_q[22:0], mosi};
			cnt_q <= 5'd1;
			got_q <= 1'b0;
		end else begin
			sr_q <= {sr_q[22:0], mosi};
			if (cnt_q == 5'(FRAME_BITS - 1)) begin
				cnt_q <= '0;
				got_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 5'd1;
			end
		end
	end

	// data leaves on the falling edge
	always_ff @(negedge link_clk) begin
		miso_q <= sr_q[23];
	end

	// before the first falling edge the reply msb shows
	assign miso = oseen_q ? miso_q : rd_q[23];
	assign miso_oe = ~select_n;

	// ---- system domain ----
	logic [2:0] pin_in; // raw asynchronous pins
	logic [2:0] acc_q; // accepted levels
	assign pin_in = {select_n, alarm_polarity_pin, loop_fault};

	// three-flop chain per pin, level accepted into a fourth flop when 2 and 3 agree
	generate
		for (genvar i = 0; i < 3; i++) begin : g_sync
			logic [SYNC_STAGES-1:0] s_q; // chain
			always_ff @(posedge sys_clk) begin
				s_q <= {s_q[SYNC_STAGES-2:0], pin_in[i]};
			end
			always_ff @(posedge sys_clk) begin
				if (s_q[1] == s_q[2]) begin
					acc_q[i] <= s_q[2];
				end
			end
		end
	endgenerate

	logic sel_q; // last accepted select level
	logic last_tog_q; // toggle of last decoded frame
	logic frame_end; // accepted select rise
	logic frame_new; // frame had clocks
	logic frame_ok; // whole number of frames
	logic [7:0] cmd; // command byte
	logic [15:0] wdata; // data word
	logic is_read; // read command
	logic is_write; // good write frame
	logic valid_wr; // write to mapped address
	logic [6:0] addr; // register address

	// link registers are quiet here: clock stopped
	assign frame_end = acc_q[2] & ~sel_q;
	assign frame_new = frame_end & (tog_q != last_tog_q);
	assign frame_ok = frame_new & got_q & (cnt_q == '0);
	assign cmd = sr_q[CMD_MSB:CMD_LSB];
	assign wdata = sr_q[15:0];
	assign addr = cmd[6:0];
	assign is_read = frame_ok & cmd[READ_BIT];
	assign is_write = frame_ok & ~cmd[READ_BIT];
	assign valid_wr = is_write & (addr != '0) & (addr <= ADDR_LAST_WRITABLE);

	// edge memory for select and frame toggle
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			sel_q <= 1'b1;
			last_tog_q <= 1'b0;
		end else begin
			sel_q <= acc_q[2];
			if (frame_end) begin
				last_tog_q <= tog_q;
			end
		end
	end

	logic [15:0] wr_policy_q; // guard bit
	logic [15:0] fault_setup_q; // fault setup
	logic [15:0] code_q; // requested output code
	logic pend_q; // a guarded write waits
	logic [6:0] pend_addr_q; // its address
	logic [15:0] pend_data_q; // its data
	logic guarded; // guard on
	logic cfg_addr; // address holds configuration
	logic app_en; // load a register now
	logic [6:0] app_addr; // target
	logic [15:0] app_data; // value

	assign guarded = wr_policy_q[GUARD_BIT];
	assign cfg_addr = (addr == ADDR_WR_POLICY) || (addr == ADDR_CODE) || (addr == ADDR_FAULT_SETUP);

	// choose what loads this cycle
	always_comb begin
		app_en = 1'b0;
		app_addr = addr;
		app_data = wdata;
		if (is_write && addr == ADDR_COMMIT) begin
			// commit key releases the pending write
			if (guarded && pend_q && wdata == COMMIT_VALUE) begin
				app_en = 1'b1;
				app_addr = pend_addr_q;
				app_data = pend_data_q;
			end
		end else if (is_write && cfg_addr && !guarded) begin
			app_en = 1'b1; // direct load at frame end
		end
	end

	// configuration registers, undefined bits dropped
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			wr_policy_q <= WR_POLICY_RST;
			fault_setup_q <= FAULT_SETUP_RST;
			// strap caught at the clock while reset holds
			code_q <= acc_q[1] ? CODE_RST_HIGH : CODE_RST_LOW;
		end else if (app_en) begin
			if (app_addr == ADDR_WR_POLICY) begin
				wr_policy_q <= app_data & WR_POLICY_MASK;
			end else if (app_addr == ADDR_CODE) begin
				code_q <= app_data; // full 16-bit code
			end else if (app_addr == ADDR_FAULT_SETUP) begin
				fault_setup_q <= app_data & FAULT_SETUP_MASK;
			end
		end
	end

	// pending slot for guarded writes; no-op never lands
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pend_q <= 1'b0;
			pend_addr_q <= '0;
			pend_data_q <= '0;
		end else if (is_write && cfg_addr && guarded) begin
			pend_q <= 1'b1;
			pend_addr_q <= addr;
			pend_data_q <= wdata;
		end else if (app_en) begin
			pend_q <= 1'b0;
		end
	end

	// read decode, unmapped and write-only read zero
	function automatic logic [15:0] read_value(input logic [6:0] a);
		if (a == ADDR_WR_POLICY) begin
			read_value = wr_policy_q;
		end else if (a == ADDR_CODE) begin
			read_value = code_q;
		end else if (a == ADDR_FAULT_SETUP) begin
			read_value = fault_setup_q;
		end else begin
			read_value = '0;
		end
	endfunction

	// reply word: register on read, loopback otherwise
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rd_q <= '0;
		end else if (is_read) begin
			rd_q <= {cmd, read_value(addr)};
		end else if (frame_ok) begin
			rd_q <= sr_q;
		end
	end

	// framing fault: set wins over status read clear
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			framing_fault_flag <= 1'b0;
		end else if (frame_new && !frame_ok) begin
			framing_fault_flag <= 1'b1;
		end else if (status_read) begin
			framing_fault_flag <= 1'b0;
		end
	end

	// ---- timers ----
	logic [$clog2(TICKS)-1:0] tick_cnt_q; // divider
	logic tick; // one cycle each 50 ms
	assign tick = (tick_cnt_q == ($clog2(TICKS))'(TICKS - 1));

	// common 50 ms step
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			tick_cnt_q <= '0;
		end else if (tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	logic [3:0] tout_cnt_q; // steps since last write
	logic [3:0] tout_limit; // field plus one
	assign tout_limit = {1'b0, fault_setup_q[TOUT_MSB:TOUT_LSB]} + 4'd1;

	// inactivity timer and timeout fault
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			tout_cnt_q <= '0;
			timeout_fault <= 1'b0;
		end else if (valid_wr) begin
			tout_cnt_q <= '0; // any write to a mapped address restarts, no-op too
			timeout_fault <= 1'b0;
		end else if (tick && !timeout_fault) begin
			tout_cnt_q <= tout_cnt_q + 4'd1;
			if (tout_cnt_q + 4'd1 == tout_limit) begin
				timeout_fault <= 1'b1;
			end
		end
	end

	logic loop_act; // unmasked loop fault
	logic alarm_q; // low alarm substituted
	logic try_q; // code restored for one step
	logic [2:0] retry_cnt_q; // steps in alarm
	assign loop_act = acc_q[0] & ~fault_setup_q[LOOP_MASK_BIT];

	// loop alarm with periodic or read-driven retry
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			alarm_q <= 1'b0;
			try_q <= 1'b0;
			retry_cnt_q <= '0;
		end else if (!loop_act) begin
			// masked or clear: retry idle
			alarm_q <= 1'b0;
			try_q <= 1'b0;
			retry_cnt_q <= '0;
		end else if (try_q) begin
			if (tick) begin
				try_q <= 1'b0;
			end
		end else if (!alarm_q) begin
			alarm_q <= 1'b1;
			retry_cnt_q <= '0;
		end else if (fault_setup_q[RETRY_DIS_BIT]) begin
			if (status_read) begin
				alarm_q <= 1'b0;
				try_q <= 1'b1;
			end
		end else if (tick) begin
			if (retry_cnt_q == fault_setup_q[RETRY_MSB:RETRY_LSB]) begin
				alarm_q <= 1'b0;
				try_q <= 1'b1;
			end else begin
				retry_cnt_q <= retry_cnt_q + 3'd1;
			end
		end
	end

	logic tout_cur; // timeout alters current
	assign tout_cur = timeout_fault & ~fault_setup_q[TOUT_CUR_MASK_BIT] & ~fault_setup_q[TOUT_REPORT_MASK_BIT];

	// output selection, loop alarm first
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			output_code <= CODE_RST_LOW;
		end else if (alarm_q) begin
			output_code <= {alarm_low, 8'h00};
		end else if (tout_cur) begin
			output_code <= {acc_q[1] ? alarm_high : alarm_low, 8'h00};
		end else begin
			output_code <= code_q;
		end
	end

	// open-drain fault pin, only ever pulled low
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			fault_pin_oe <= 1'b0;
		end else begin
			fault_pin_oe <= (acc_q[0] & ~fault_setup_q[LOOP_PIN_DIS_BIT])
				| (timeout_fault & ~fault_setup_q[TOUT_REPORT_MASK_BIT])
				| framing_fault_flag;
		end
	end
	assign fault_pin_n = 1'b0;

	// ---- checks ----
	a_guard_holds: assert property (@(posedge sys_clk) disable iff (!rstn)
		is_write && guarded && addr == ADDR_CODE |=> $stable(code_q))
		else $error("guarded write changed code");
	a_direct_write: assert property (@(posedge sys_clk) disable iff (!rstn)
		is_write && !guarded && addr == ADDR_CODE |=> code_q == $past(wdata))
		else $error("direct write not applied");
	a_commit_load: assert property (@(posedge sys_clk) disable iff (!rstn)
		is_write && guarded && pend_q && addr == ADDR_COMMIT && wdata == COMMIT_VALUE
		&& pend_addr_q == ADDR_CODE |=> code_q == $past(pend_data_q))
		else $error("commit did not load");
	a_nop_keeps: assert property (@(posedge sys_clk) disable iff (!rstn)
		is_write && addr == ADDR_NOP |=> $stable(code_q) && $stable(fault_setup_q) && tout_cnt_q == '0)
		else $error("no-op changed state");
	a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
		is_read && addr == ADDR_WR_POLICY |=> rd_q[15:1] == '0)
		else $error("reserved bits read nonzero");
	a_loop_first: assert property (@(posedge sys_clk) disable iff (!rstn)
		alarm_q && tout_cur |=> output_code == {$past(alarm_low), 8'h00})
		else $error("loop alarm lost priority");
	a_pin_loop: assert property (@(posedge sys_clk) disable iff (!rstn)
		acc_q[0] && !fault_setup_q[LOOP_PIN_DIS_BIT] |=> fault_pin_oe)
		else $error("loop fault not on pin");
	a_tout_limit: assert property (@(posedge sys_clk) disable iff (!rstn)
		tick && !valid_wr && !timeout_fault && tout_cnt_q + 4'd1 == tout_limit |=> timeout_fault)
		else $error("timeout not raised");
	a_tout_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
		valid_wr |=> !timeout_fault ##1 1'b1)
		else $error("write left timeout set");
	a_frame_fault: assert property (@(posedge sys_clk) disable iff (!rstn)
		frame_new && !frame_ok |=> framing_fault_flag)
		else $error("bad frame not flagged");
	a_no_retry: assert property (@(posedge sys_clk) disable iff (!rstn)
		alarm_q && loop_act && fault_setup_q[RETRY_DIS_BIT] && !status_read |=> alarm_q)
		else $error("retried while disabled");
endmodule

// >>> verification/ldr_master.sv
// Purpose: serial master model that frames commands into the bank
// Assumes: link clock idles low and runs only inside a frame
// Notes: mosi is inverted between frames so stale bits never match
module ldr_master (
	output logic link_clk,
	output logic select_n,
	output logic mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle levels before the first frame
	initial begin
		link_clk = 1'b0;
		select_n = 1'b1;
		mosi = 1'b0;
	end
	// n clocks, msb first, word repeats every 24 bits; rx is the reply
	task automatic commit_field(input int n, input logic [23:0] w, output logic [23:0] rx);
		rx = 24'h000000;
		#3;
		select_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			mosi = w[23 - (i % 24)];
			#24;
			rx = {rx[22:0], miso};
			link_clk = 1'b1;
			#24;
			link_clk = 1'b0;
		end
		#24;
		select_n = 1'b1;
		// released line shows the inverse of the last bit
		mosi = ~mosi;
		// select high gap well above the decode time
		#200;
	endtask
endmodule

// >>> verification/loop_dac_register_bank_bench.sv
// Purpose: self-checking bench for the register bank
// Assumes: timer step shortened to TK cycles
// Notes: master model drives the link, bench drives the rest
module loop_dac_register_bank_bench import ldr_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TK = 200; // cycles per timer step
	logic sys_clk, rstn, link_clk, select_n, mosi, miso, miso_oe, pol;
	logic loop_fault, status_read, fault_pin_n, fault_pin_oe, timeout_fault, framing_fault_flag;
	logic [7:0] alarm_low, alarm_high;
	logic [15:0] output_code, d;
	logic [23:0] rx;
	int err_count, compares, cyc;
	// partner on the link side
	ldr_master mst_u (.link_clk(link_clk), .select_n(select_n), .mosi(mosi), .miso(miso));
	ldr_bank #(.TICKS(TK)) dut_u (.sys_clk(sys_clk), .rstn(rstn), .link_clk(link_clk),
		.select_n(select_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
		.alarm_polarity_pin(pol), .loop_fault(loop_fault), .status_read(status_read),
		.alarm_low(alarm_low), .alarm_high(alarm_high), .output_code(output_code),
		.fault_pin_n(fault_pin_n), .fault_pin_oe(fault_pin_oe), .timeout_fault(timeout_fault),
		.framing_fault_flag(framing_fault_flag));
	// system clock, 8 ns
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			stop_test();
		end
	end
	// compare and report
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// register write frame
	task automatic wr(input logic [6:0] a, input logic [15:0] v);
		mst_u.commit_field(24, {1'b0, a, v}, rx);
	endtask
	// read command, then a no-operation frame carries the data back
	task automatic rd(input logic [6:0] a, output logic [15:0] v);
		mst_u.commit_field(24, {1'b1, a, 16'h0000}, rx);
		mst_u.commit_field(24, {8'h02, 16'h0000}, rx);
		v = rx[15:0];
	endtask
	task automatic pulse();
		@(posedge sys_clk) status_read <= 1'b1;
		@(posedge sys_clk) status_read <= 1'b0;
		cy(3);
	endtask
	task automatic do_reset(input logic p);
		@(posedge sys_clk) rstn <= 1'b0;
		pol <= p;
		cy(8);
		rstn <= 1'b1;
		cy(2);
	endtask
	// defaults after reset with the polarity pin low
	task automatic t_reset();
		do_reset(1'b0);
		chk(output_code, 16'h2400, "low reset code");
		chk({15'h0, fault_pin_oe}, 16'h0000, "pin idle");
		chk({15'h0, fault_pin_n}, 16'h0000, "pin pulls low only");
		chk({15'h0, miso_oe}, 16'h0000, "miso released");
		rd(7'h05, d);
		chk(d, 16'h0102, "setup reset");
		rd(7'h03, d);
		chk(d, 16'h0000, "policy reset");
	endtask
	// direct writes and undefined bits
	task automatic t_write();
		wr(7'h04, 16'h1234);
		cy(8);
		chk(output_code, 16'h1234, "direct write");
		rd(7'h04, d);
		chk(d, 16'h1234, "code readback");
		wr(7'h05, 16'hFFFF);
		rd(7'h05, d);
		chk(d, 16'h07FF, "setup spare bits");
		wr(7'h03, 16'hFFFE);
		rd(7'h03, d);
		chk(d, 16'h0000, "policy spare bits");
		wr(7'h05, 16'h0102);
	endtask
	// guarded writes wait for the commit key
	task automatic t_guard();
		wr(7'h03, 16'h0001);
		wr(7'h02, 16'h5555);
		cy(8);
		chk(output_code, 16'h1234, "nop keeps code");
		wr(7'h04, 16'hABCD);
		cy(8);
		chk(output_code, 16'h1234, "held until commit");
		wr(7'h01, 16'h00FF);
		cy(8);
		chk(output_code, 16'hABCD, "commit loads");
		wr(7'h03, 16'h0000);
		wr(7'h01, 16'h00FF);
		rd(7'h03, d);
		chk(d, 16'h0000, "guard off again");
	endtask
	// short frame refused, double frame decodes the last word
	task automatic t_frame();
		mst_u.commit_field(23, {8'h04, 16'h0000}, rx);
		cy(8);
		chk({15'h0, framing_fault_flag}, 16'h0001, "framing flag");
		chk(output_code, 16'hABCD, "short frame ignored");
		pulse();
		chk({15'h0, framing_fault_flag}, 16'h0000, "flag cleared");
		mst_u.commit_field(48, {8'h04, 16'h2222}, rx);
		cy(8);
		chk(output_code, 16'h2222, "48 clock frame");
		chk({15'h0, framing_fault_flag}, 16'h0000, "48 is no fault");
	endtask
	// inactivity timeout, its clearing and its report mask
	task automatic t_timeout();
		wr(7'h02, 16'h0000);
		cy(TK - 50);
		chk({15'h0, timeout_fault}, 16'h0000, "no early timeout");
		cy(TK + 60);
		chk({15'h0, timeout_fault}, 16'h0001, "timeout after 2 steps");
		chk({15'h0, fault_pin_oe}, 16'h0001, "timeout on pin");
		chk(output_code, 16'h3000, "timeout low alarm");
		wr(7'h02, 16'h0000);
		chk({15'h0, timeout_fault}, 16'h0000, "write clears timeout");
		chk(output_code, 16'h2222, "code back");
		wr(7'h05, 16'h0103);
		cy(2 * TK + 10);
		chk({15'h0, fault_pin_oe}, 16'h0000, "report masked");
		chk(output_code, 16'h2222, "no alarm current");
	endtask
	// loop fault: alarm, retry, disable, masks
	task automatic t_loop();
		int n;
		wr(7'h05, 16'h010E);
		loop_fault <= 1'b1;
		cy(10);
		chk(output_code, 16'h3000, "loop alarm");
		chk({15'h0, fault_pin_oe}, 16'h0001, "loop on pin");
		for (n = 0; n < 3 * TK && output_code !== 16'h2222; n++) cy(1);
		chk({15'h0, n >= TK - 20 && n < 3 * TK}, 16'h0001, "retry spacing");
		wr(7'h05, 16'h018E);
		cy(3 * TK);
		chk(output_code, 16'h3000, "no retry when off");
		pulse();
		chk(output_code, 16'h2222, "status read restores");
		wr(7'h05, 16'h014E);
		cy(8);
		chk(output_code, 16'h2222, "loop current masked");
		wr(7'h05, 16'h012E);
		cy(8);
		chk({15'h0, fault_pin_oe}, 16'h0000, "loop pin disabled");
		loop_fault <= 1'b0;
	endtask
	// polarity pin high: reset code, high alarm, loop level wins
	task automatic t_high();
		do_reset(1'b1);
		chk(output_code, 16'hE800, "high reset code");
		cy(2 * TK + 10);
		chk(output_code, 16'hC000, "timeout high alarm");
		loop_fault <= 1'b1;
		cy(10);
		chk(output_code, 16'h3000, "loop over timeout");
		loop_fault <= 1'b0;
	endtask
	task automatic stop_test();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		rstn = 1'b0;
		pol = 1'b0;
		loop_fault = 1'b0;
		status_read = 1'b0;
		alarm_low = 8'h30;
		alarm_high = 8'hC0;
		t_reset();
		t_write();
		t_guard();
		t_frame();
		t_timeout();
		t_loop();
		t_high();
		stop_test();
	end
endmodule
